// ==== rtl/ubm_pkg.sv ====
package ubm_pkg;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_RXBUF = 8'h00;
	localparam logic [7:0] OFS_TXBUF = 8'h04;
	localparam logic [7:0] OFS_DIVLO = 8'h08;
	localparam logic [7:0] OFS_DIVHI = 8'h0C;
	localparam logic [7:0] OFS_IRQEN = 8'h10;
	localparam logic [7:0] OFS_LINE = 8'h14;
	localparam logic [7:0] OFS_MCTL = 8'h18;
	localparam logic [7:0] OFS_MSTAT = 8'h1C;
	localparam logic [7:0] OFS_SCRATCH = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	// ==========================================
	// Field positions
	localparam int MSR_DCD_CHG = 3;
	localparam int MSR_CTS = 4;
	localparam int MSR_DSR = 5;
	localparam int MSR_RI = 6;
	localparam int MSR_DCD = 7;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_USER_OUTPUT_ONE = 2;
	localparam int MC_USER_OUTPUT_TWO = 3;
	localparam int MC_LOOP = 4;
	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_MS = 3;

	// ==========================================
	// Reset values and counts
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [7:0] LINE_RESET = 8'h03;
	localparam logic [3:0] OVERSAMPLE = 4'hF;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam int FIFO_DEPTH = 16;

	// ==========================================
	// Transmit and receive states
	typedef enum logic [3:0]
	{
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} ubm_tx_e;

	typedef enum logic [3:0]
	{
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} ubm_rx_e;

	// Modem pins grouped
	typedef struct packed
	{
		logic cts;
		logic dsr;
		logic ri;
		logic dcd;
	} ubm_modem_s;

endpackage

// ==== rtl/ubm_uart.sv ====
`timescale 1ns/10ps
// Contract
// RQ1 - Carrier change sets flag, may interrupt
// RQ2 - Status bit4 is inverted CTS, loop RTS
// RQ3 - Status bit5 is inverted DSR, loop DTR
// RQ4 - Status bit6 is inverted RI, loop USER_OUTPUT_ONE
// RQ5 - Status bit7 is inverted DCD, loop USER_OUTPUT_TWO
// RQ6 - Divide reference by 1 to 65535
// RQ7 - Generator output is sixteen times bitrate
// RQ8 - Software divisor equals reference over rate*16
// RQ9 - Divisor held in two 8-bit latches
// RQ10 - Software loads both latches at initialisation
// RQ11 - Latch write reloads baud counter at once
// RQ12 - Receive buffer is 16-byte FIFO, rx clock
// RQ13 - Receive shifter assembles serial input characters
// RQ14 - Received data interrupt cleared on read
// RQ15 - Framing taken from line control register
// RQ16 - Scratchpad stores byte, affects nothing
// RQ17 - Transmit buffer 16-byte FIFO, baud timed
// RQ18 - Idle shifter takes next byte, shifts out
// RQ19 - Holding-empty interrupt cleared by CPU load
// RQ20 - Status read clears change flags
// RQ21 - Loopback routes control outputs to inputs
// RQ22 - Holding-empty set on transfer, cleared on write
// RQ23 - Baud counter counts down, reloads, pulses
module ubm_uart
#(
	parameter int DEPTH = ubm_pkg::FIFO_DEPTH
)
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic clkEn, // Freezes all state when low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic rxClkEn, // Receive 16x tick
	input wire logic serialInput, // Serial data in
	output logic serialOutput, // Serial data out
	input wire ubm_pkg::ubm_modem_s modemIn_n, // Modem inputs, low active
	output logic dtrOut_n, // Terminal ready pin
	output logic rtsOut_n, // Request to send pin
	output logic userOutputOne_n, // User output one pin
	output logic userOutputTwo_n, // User output two pin
	output logic baudClockOut, // 16x tick out
	output logic irq // Interrupt, high
);
	import ubm_pkg::*;

	initial
	begin
		if (DEPTH < 2 || DEPTH > 256)
			$error("DEPTH out of range");
	end

	localparam int AW = $clog2(DEPTH);

	// ==========================================
	// State record
	typedef struct packed
	{
		logic [7:0] divLo;
		logic [7:0] divHi;
		logic [15:0] baudCnt;
		logic baudTick;
		logic [7:0] irqEn;
		logic [7:0] lineCtl;
		logic [7:0] modemCtl;
		logic [7:0] scratch;
		logic dcdChanged;
		logic dcdPrev;
		logic txEmpty;
		ubm_tx_e txState;
		logic [3:0] txTick;
		logic [3:0] txBit;
		logic [7:0] txShift;
		logic txLine;
		logic [AW:0] txWp;
		logic [AW:0] txRp;
		ubm_rx_e rxState;
		logic [3:0] rxTick;
		logic [3:0] rxBit;
		logic [7:0] rxShift;
		logic [AW:0] rxWp;
		logic [AW:0] rxRp;
		logic rdWait; // Read wait state taken
		logic [31:0] rdata;
	} ubm_state_s;

	ubm_state_s st_r;
	ubm_state_s st_nxt;
	logic [7:0] txMem [DEPTH];
	logic [7:0] rxMem [DEPTH];

	// Derived values
	logic access;
	logic wrAcc;
	logic rdAcc;
	logic rdTake;
	logic loopOn;
	logic [3:0] msrLevels;
	logic dcdNow;
	logic [3:0] dataBits;
	logic parityOn;
	logic txFifoEmpty;
	logic txFifoFull;
	logic rxFifoEmpty;
	logic rxFifoFull;
	logic txPush;
	logic txPop;
	logic rxPush;
	logic rxPop;
	logic rxIn;
	logic [15:0] divisor;

	// ==========================================
	// Bus decode and modem view
	always_comb
	begin
		access = psel && penable;
		wrAcc = access && pwrite;
		rdAcc = access && !pwrite;
		// First read access cycle latches data and waits;
		// pops and clears happen only here, never twice
		rdTake = rdAcc && !st_r.rdWait;
		loopOn = st_r.modemCtl[MC_LOOP];
		divisor = {st_r.divHi, st_r.divLo}; // RQ9
		// Loopback substitutes control bits for pins
		if (loopOn) // RQ21
			msrLevels = {st_r.modemCtl[MC_USER_OUTPUT_TWO], st_r.modemCtl[MC_USER_OUTPUT_ONE],
				st_r.modemCtl[MC_DTR], st_r.modemCtl[MC_RTS]}; // RQ2 RQ3 RQ4 RQ5
		else
			msrLevels = {~modemIn_n.dcd, ~modemIn_n.ri,
				~modemIn_n.dsr, ~modemIn_n.cts}; // RQ2 RQ3 RQ4 RQ5
		dcdNow = msrLevels[3];
		// Framing from line control
		dataBits = 4'h5 + {2'b00, st_r.lineCtl[1:0]}; // RQ15
		parityOn = st_r.lineCtl[3];
		txFifoEmpty = st_r.txWp == st_r.txRp;
		txFifoFull = st_r.txWp == {~st_r.txRp[AW], st_r.txRp[AW-1:0]};
		rxFifoEmpty = st_r.rxWp == st_r.rxRp;
		rxFifoFull = st_r.rxWp == {~st_r.rxRp[AW], st_r.rxRp[AW-1:0]};
		txPush = wrAcc && paddr == OFS_TXBUF && !txFifoFull;
		rxPop = rdTake && paddr == OFS_RXBUF && !rxFifoEmpty;
		txPop = st_r.txState == TX_IDLE && st_r.baudTick && !txFifoEmpty;
		rxIn = loopOn ? st_r.txLine : serialInput;
		rxPush = rxClkEn && st_r.rxState == RX_STOP && st_r.rxTick == MID_SAMPLE
			&& !rxFifoFull;
	end

	// ==========================================
	// Next-state logic
	always_comb
	begin
		st_nxt = st_r;
		// Register writes
		if (wrAcc)
		begin
			if (paddr == OFS_DIVLO)
				st_nxt.divLo = pwdata[7:0]; // RQ9
			else if (paddr == OFS_DIVHI)
				st_nxt.divHi = pwdata[7:0]; // RQ9
			else if (paddr == OFS_IRQEN)
				st_nxt.irqEn = pwdata[7:0];
			else if (paddr == OFS_LINE)
				st_nxt.lineCtl = pwdata[7:0];
			else if (paddr == OFS_MCTL)
				st_nxt.modemCtl = {3'b000, pwdata[4:0]};
			else if (paddr == OFS_SCRATCH)
				st_nxt.scratch = pwdata[7:0]; // RQ16
		end
		// Baud counter counts down and reloads
		st_nxt.baudTick = 1'b0;
		if (wrAcc && (paddr == OFS_DIVLO || paddr == OFS_DIVHI))
			st_nxt.baudCnt = paddr == OFS_DIVLO
				? {st_r.divHi, pwdata[7:0]} : {pwdata[7:0], st_r.divLo}; // RQ11
		else if (st_r.baudCnt <= 16'h0001)
		begin
			st_nxt.baudCnt = divisor; // RQ6 RQ23
			st_nxt.baudTick = 1'b1; // RQ7 RQ23
		end
		else
			st_nxt.baudCnt = st_r.baudCnt - 16'h0001; // RQ23
		// Carrier change flag; set beats read clear
		st_nxt.dcdPrev = dcdNow;
		if (rdTake && paddr == OFS_MSTAT)
			st_nxt.dcdChanged = 1'b0; // RQ20
		if (dcdNow != st_r.dcdPrev)
			st_nxt.dcdChanged = 1'b1; // RQ1
		// Holding empty flag
		if (txPush)
			st_nxt.txEmpty = 1'b0; // RQ22
		else if (txPop && st_r.txWp == st_r.txRp + 1'b1)
			st_nxt.txEmpty = 1'b1; // RQ22
		// Transmit FIFO pointers
		if (txPush)
			st_nxt.txWp = st_r.txWp + 1'b1; // RQ17
		if (txPop)
			st_nxt.txRp = st_r.txRp + 1'b1; // RQ17
		// Transmit shifter, timed by baud tick
		if (st_r.baudTick)
		begin
			case (st_r.txState)
				TX_IDLE:
				begin
					st_nxt.txLine = 1'b1;
					if (!txFifoEmpty)
					begin
						st_nxt.txShift = txMem[st_r.txRp[AW-1:0]]; // RQ18
						st_nxt.txState = TX_START;
						st_nxt.txTick = 4'h0;
						st_nxt.txLine = 1'b0;
					end
				end
				TX_START:
				begin
					st_nxt.txTick = st_r.txTick + 4'h1;
					if (st_r.txTick == OVERSAMPLE)
					begin
						st_nxt.txState = TX_DATA;
						st_nxt.txBit = 4'h0;
						st_nxt.txLine = st_r.txShift[0]; // RQ18
					end
				end
				TX_DATA:
				begin
					st_nxt.txTick = st_r.txTick + 4'h1;
					if (st_r.txTick == OVERSAMPLE)
					begin
						st_nxt.txBit = st_r.txBit + 4'h1;
						st_nxt.txShift = {1'b0, st_r.txShift[7:1]};
						if (st_r.txBit + 4'h1 == dataBits)
						begin
							st_nxt.txState = TX_STOP;
							st_nxt.txLine = parityOn
								? ~(^(st_r.txShift & 8'hFF) ^ st_r.lineCtl[4])
								: 1'b1;
						end
						else
							st_nxt.txLine = st_r.txShift[1]; // RQ18
					end
				end
				TX_STOP:
				begin
					st_nxt.txTick = st_r.txTick + 4'h1;
					if (st_r.txTick == OVERSAMPLE)
					begin
						st_nxt.txLine = 1'b1;
						st_nxt.txState = TX_IDLE;
					end
				end
				default:
					st_nxt.txState = TX_IDLE;
			endcase
		end
		// Receive shifter on 16x receive tick
		if (rxClkEn) // RQ12
		begin
			st_nxt.rxTick = st_r.rxTick + 4'h1;
			case (st_r.rxState)
				RX_IDLE:
				begin
					st_nxt.rxTick = 4'h0;
					if (!rxIn)
						st_nxt.rxState = RX_START;
				end
				RX_START:
					if (st_r.rxTick == MID_SAMPLE)
					begin
						st_nxt.rxTick = 4'h0;
						st_nxt.rxBit = 4'h0;
						st_nxt.rxState = rxIn ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (st_r.rxTick == OVERSAMPLE)
					begin
						st_nxt.rxShift = {rxIn, st_r.rxShift[7:1]}; // RQ13
						st_nxt.rxBit = st_r.rxBit + 4'h1;
						if (st_r.rxBit + 4'h1 == dataBits)
							st_nxt.rxState = RX_STOP;
					end
				RX_STOP:
					if (st_r.rxTick == MID_SAMPLE)
						st_nxt.rxState = RX_IDLE;
				default:
					st_nxt.rxState = RX_IDLE;
			endcase
		end
		if (rxPush)
			st_nxt.rxWp = st_r.rxWp + 1'b1; // RQ12 RQ13
		if (rxPop)
			st_nxt.rxRp = st_r.rxRp + 1'b1; // RQ14
		// Read data, latched in the wait cycle and held
		// so it stands at the completing edge
		st_nxt.rdWait = rdTake;
		if (rdTake)
		begin
			st_nxt.rdata = 32'h0000_0000;
			if (paddr == OFS_RXBUF)
				st_nxt.rdata[7:0] = rxMem[st_r.rxRp[AW-1:0]];
			else if (paddr == OFS_DIVLO)
				st_nxt.rdata[7:0] = st_r.divLo;
			else if (paddr == OFS_DIVHI)
				st_nxt.rdata[7:0] = st_r.divHi;
			else if (paddr == OFS_IRQEN)
				st_nxt.rdata[7:0] = st_r.irqEn;
			else if (paddr == OFS_LINE)
				st_nxt.rdata[7:0] = st_r.lineCtl;
			else if (paddr == OFS_MCTL)
				st_nxt.rdata[7:0] = st_r.modemCtl;
			else if (paddr == OFS_MSTAT)
				st_nxt.rdata[7:0] = {msrLevels, st_r.dcdChanged, 3'b000};
			else if (paddr == OFS_SCRATCH)
				st_nxt.rdata[7:0] = st_r.scratch; // RQ16
			else if (paddr == OFS_STATUS)
				st_nxt.rdata[7:0] = {5'b00000, !rxFifoEmpty,
					st_r.txEmpty && st_r.txState == TX_IDLE, st_r.txEmpty};
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= '0;
			st_r.divLo <= DIV_RESET[7:0];
			st_r.baudCnt <= DIV_RESET;
			st_r.lineCtl <= LINE_RESET;
			st_r.txEmpty <= 1'b1;
			st_r.txState <= TX_IDLE;
			st_r.txLine <= 1'b1;
			st_r.rxState <= RX_IDLE;
		end
		else if (clkEn)
			st_r <= st_nxt;
	end

	// FIFO storage
	always_ff @(posedge clk)
	begin
		if (clkEn && txPush)
			txMem[st_r.txWp[AW-1:0]] <= pwdata[7:0]; // RQ17
		if (clkEn && rxPush)
			rxMem[st_r.rxWp[AW-1:0]] <= st_r.rxShift; // RQ12
	end

	// ==========================================
	// Outputs
	always_comb
	begin
		prdata = st_r.rdata;
		pready = !rdTake; // Reads take one wait state
		pslverr = access && !rdTake && paddr > OFS_STATUS;
		serialOutput = loopOn ? 1'b1 : st_r.txLine;
		dtrOut_n = loopOn || !st_r.modemCtl[MC_DTR];
		rtsOut_n = loopOn || !st_r.modemCtl[MC_RTS];
		userOutputOne_n = loopOn || !st_r.modemCtl[MC_USER_OUTPUT_ONE];
		userOutputTwo_n = loopOn || !st_r.modemCtl[MC_USER_OUTPUT_TWO];
		baudClockOut = st_r.baudTick; // RQ7
		irq = (st_r.irqEn[IE_RX] && !rxFifoEmpty) // RQ14
			|| (st_r.irqEn[IE_TX] && st_r.txEmpty) // RQ19
			|| (st_r.irqEn[IE_MS] && st_r.dcdChanged); // RQ1
	end

endmodule // ubm_uart

// ==== verification/ubm_modem_model.sv ====
`timescale 1ns/10ps
module ubm_modem_model
(
	input wire logic clk, // Clock
	output logic rxClkEn, // Receive tick
	output logic serialInput, // Line to block
	output ubm_pkg::ubm_modem_s modemIn_n // Modem pins
);
	import ubm_pkg::*;
	// ==========
	// Idle line, inactive pins
	initial
	begin
		rxClkEn = 1'b0;
		serialInput = 1'b1;
		modemIn_n = 4'hF;
	end
	// Free running tick, every other cycle
	always @(posedge clk) rxClkEn <= ~rxClkEn;
	// Change modem pin levels
	task automatic drivePins(input ubm_modem_s p);
		modemIn_n <= p;
	endtask
	// Start, data LSB first, stop; 16 ticks a bit
	task automatic sendByte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			serialInput <= f[i];
			repeat (31) @(posedge clk);
		end
	endtask
endmodule // ubm_modem_model

// ==== verification/ubm_uart_chk.sv ====
`timescale 1ns/10ps
module ubm_uart_chk
(
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic clkEn, // Enable
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Write
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic serialOutput, // Serial out
	input wire ubm_pkg::ubm_modem_s modemIn_n, // Modem pins
	input wire logic dtrOut_n, // DTR pin
	input wire logic rtsOut_n, // RTS pin
	input wire logic userOutputOne_n, // User pin
	input wire logic userOutputTwo_n, // User pin
	input wire logic baudClockOut, // Tick
	input wire logic irq // Interrupt
);
	import ubm_pkg::*;
	logic wr, rdMs, clean, pend, aged;
	logic [15:0] div, dEff, cnt;
	logic [4:0] mc;
	logic [3:0] ie;
	logic [2:0] sinceRd;
	// ==========
	// Shadows of written registers
	assign wr = psel && penable && pwrite && clkEn;
	assign rdMs = psel && penable && !pwrite && clkEn && paddr == OFS_MSTAT;
	assign dEff = (div == 16'h0000) ? 16'h0001 : div;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			div <= DIV_RESET;
			mc <= 5'h00;
			ie <= 4'h0;
			cnt <= 16'h0000;
			clean <= 1'b0;
			pend <= 1'b0;
			sinceRd <= 3'h0;
		end
		else
		begin
			aged = !mc[MC_LOOP] && !$past(mc[MC_LOOP], 5) && sinceRd == 3'h7;
			aged = aged && $past(modemIn_n.dcd, 4) != $past(modemIn_n.dcd, 5);
			cnt <= baudClockOut ? 16'h0001 : cnt + {15'h0000, clkEn};
			clean <= clean || baudClockOut;
			sinceRd <= rdMs ? 3'h0 : sinceRd + {2'h0, sinceRd != 3'h7};
			pend <= !rdMs && (pend || aged);
			if (wr && (paddr == OFS_DIVLO || paddr == OFS_DIVHI))
			begin
				cnt <= 16'h0000;
				clean <= 1'b0;
			end
			if (wr && paddr == OFS_DIVLO) div[7:0] <= pwdata[7:0];
			if (wr && paddr == OFS_DIVHI) div[15:8] <= pwdata[7:0];
			if (wr && paddr == OFS_MCTL) mc <= pwdata[4:0];
			if (wr && paddr == OFS_IRQEN) ie <= pwdata[3:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence sQuiet;
		$past(modemIn_n, 4) == modemIn_n;
	endsequence
	sequence sLoopRd;
		rdMs && mc[MC_LOOP] ##0 $past(mc, 2) == mc;
	endsequence
	// ==========
	// Checks
	AST_MS_LEVELS: assert property (rdMs && !mc[MC_LOOP] ##0 sQuiet |=>
		prdata[7:4] == ~$past({modemIn_n.dcd, modemIn_n.ri, modemIn_n.dsr, modemIn_n.cts}))
		else $error("modem levels wrong");
	AST_MS_LOOP: assert property (sLoopRd |=>
		prdata[7:4] == $past({mc[MC_USER_OUTPUT_TWO], mc[MC_USER_OUTPUT_ONE], mc[MC_DTR], mc[MC_RTS]}))
		else $error("loop levels wrong");
	AST_PINS: assert property ($past(mc) == mc |->
		{dtrOut_n, rtsOut_n, userOutputOne_n, userOutputTwo_n} == (mc[MC_LOOP] ?
		4'hF : ~{mc[MC_DTR], mc[MC_RTS], mc[MC_USER_OUTPUT_ONE], mc[MC_USER_OUTPUT_TWO]}))
		else $error("control pins wrong");
	AST_SERIAL_OUTPUT_LOOP: assert property (mc[MC_LOOP] && $past(mc[MC_LOOP]) |-> serialOutput)
		else $error("serial out not high in loop");
	AST_DCD_SET: assert property (rdMs && pend |=> prdata[MSR_DCD_CHG])
		else $error("carrier change flag missing");
	AST_DCD_IRQ: assert property (ie[IE_MS] && pend && !rdMs |-> irq)
		else $error("modem interrupt missing");
	AST_IRQ_SRC: assert property (irq |-> ie[IE_RX] || ie[IE_TX] || ie[IE_MS])
		else $error("interrupt without enable");
	AST_BAUD_GAP: assert property (baudClockOut && clean |-> cnt == dEff)
		else $error("baud period wrong");
	AST_BAUD_LOAD: assert property ({1'b0, cnt} <= {1'b0, dEff} + 17'h00002)
		else $error("baud tick late");
endmodule // ubm_uart_chk
bind ubm_uart ubm_uart_chk chk_u (.*);

// ==== verification/ubm_uart_test.sv ====
`timescale 1ns/10ps
module ubm_uart_test;
	import ubm_pkg::*;
	localparam int DIVV = 20000000 / (625000 * 16);
	localparam int BITC = 16 * DIVV;
	logic clk, rst, clkEn, psel, penable, pwrite, pready, pslverr, e;
	logic rxClkEn, serialInput, serialOutput, baudClockOut, irq;
	logic dtrOut_n, rtsOut_n, userOutputOne_n, userOutputTwo_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pins;
	ubm_modem_s modemIn_n;
	logic [7:0] regA [7] = '{OFS_DIVLO, OFS_DIVHI, OFS_LINE, OFS_MCTL,
		OFS_SCRATCH, OFS_MSTAT, OFS_STATUS};
	logic [7:0] regV [7] = '{8'h01, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03};
	logic [15:0] divTab [2] = '{16'h0003, 16'h0100};
	ubm_modem_s pinTab [3] = '{4'b1110, 4'b0100, 4'b0101};
	int fail_count = 0;
	int num_checks = 0;
	assign pins = {dtrOut_n, rtsOut_n, userOutputOne_n, userOutputTwo_n};
	ubm_uart dut_u (.*);
	ubm_modem_model model_u (.*);
	// ==========
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Select 0 irq, 1 tick, 2 serial out
	function automatic logic pick(input int w);
		return w == 0 ? irq : (w == 1 ? baudClockOut : serialOutput);
	endfunction
	task automatic waitFor(input int w, input logic v);
		for (int n = 0; pick(w) !== v; n++)
		begin
			@(posedge clk);
			#1;
			if (n > 5000)
			begin
				fail_count++;
				finish_test();
			end
		end
	endtask
	// One APB transfer; read data taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (int n = 0; pready !== 1'b1; n++)
		begin
			if (n > 50)
			begin
				fail_count++;
				finish_test();
			end
			@(posedge clk);
		end
		e = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic expectTx(input logic [7:0] x);
		logic [7:0] b;
		waitFor(2, 1'b0);
		repeat (BITC / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BITC) @(posedge clk);
			b[i] = serialOutput;
		end
		repeat (BITC) @(posedge clk);
		chk("tx stop", 32'h1, 32'(serialOutput));
		chk("tx byte", 32'(x), 32'(b));
	endtask
	// ==========
	// Main sequence
	initial
	begin
		logic dPrev;
		int n;
		rst = 1'b1;
		clkEn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (regA[i])
		begin
			apb(1'b0, regA[i], 32'h0);
			chk("reset value", {24'h0, regV[i]}, q);
		end
		apb(1'b1, OFS_SCRATCH, 32'hA5);
		apb(1'b0, OFS_SCRATCH, 32'h0);
		chk("scratch", 32'hA5, q);
		apb(1'b0, OFS_LINE, 32'h0);
		chk("line after scratch", 32'h3, q);
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped error", 32'h1, 32'(e));
		foreach (divTab[k])
		begin
			apb(1'b1, OFS_DIVLO, 32'(divTab[k][7:0]));
			apb(1'b1, OFS_DIVHI, 32'(divTab[k][15:8]));
			apb(1'b0, OFS_DIVHI, 32'h0);
			chk("divisor high", 32'(divTab[k][15:8]), q);
			waitFor(1, 1'b1);
			n = 0;
			do
			begin
				@(posedge clk);
				#1;
				n++;
			end
			while (baudClockOut !== 1'b1 && n < 300);
			chk("tick period", 32'(divTab[k]), 32'(n));
		end
		apb(1'b1, OFS_DIVLO, 32'(DIVV));
		apb(1'b1, OFS_DIVHI, 32'h0);
		apb(1'b1, OFS_IRQEN, 32'h2);
		chk("tx empty irq", 32'h1, 32'(irq));
		apb(1'b1, OFS_TXBUF, 32'h5A);
		apb(1'b1, OFS_TXBUF, 32'hC3);
		chk("irq after load", 32'h0, 32'(irq));
		expectTx(8'h5A);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("holding full", 32'h0, q & 32'h1);
		expectTx(8'hC3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("holding empty", 32'h1, q & 32'h1);
		chk("tx irq again", 32'h1, 32'(irq));
		apb(1'b1, OFS_IRQEN, 32'h1);
		model_u.sendByte(8'h3C);
		waitFor(0, 1'b1);
		apb(1'b0, OFS_RXBUF, 32'h0);
		chk("rx byte", 32'h3C, q);
		chk("rx irq cleared", 32'h0, 32'(irq));
		apb(1'b1, OFS_IRQEN, 32'h8);
		dPrev = 1'b1;
		foreach (pinTab[k])
		begin
			@(posedge clk);
			model_u.drivePins(pinTab[k]);
			repeat (8) @(posedge clk);
			#1;
			if (k == 0) chk("modem irq", 32'h1, 32'(irq));
			for (int r = 0; r < 2; r++)
			begin
				apb(1'b0, OFS_MSTAT, 32'h0);
				chk("modem status", 32'({~pinTab[k].dcd, ~pinTab[k].ri, ~pinTab[k].dsr,
					~pinTab[k].cts, pinTab[k].dcd != dPrev && r == 0}), 32'(q[7:3]));
			end
			if (k == 0) chk("modem irq cleared", 32'h0, 32'(irq));
			dPrev = pinTab[k].dcd;
		end
		apb(1'b1, OFS_MCTL, 32'h05);
		repeat (2) @(posedge clk);
		chk("pins", 32'h5, 32'(pins));
		apb(1'b1, OFS_MCTL, 32'h1A);
		repeat (2) @(posedge clk);
		chk("loop pins", 32'hF, 32'(pins));
		chk("loop serial out", 32'h1, 32'(serialOutput));
		apb(1'b0, OFS_MSTAT, 32'h0);
		chk("loop status", 32'h9, 32'(q[7:4]));
		apb(1'b1, OFS_TXBUF, 32'h96);
		repeat (11 * BITC) @(posedge clk);
		apb(1'b0, OFS_RXBUF, 32'h0);
		chk("loop byte", 32'h96, q);
		finish_test();
	end
endmodule // ubm_uart_test
